/* File: shared/smw_pkg.sv */
package smw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS_OFS   = 8'h00; // Status flags, read only
  localparam logic [7:0] REG_REGCTL_OFS   = 8'h04; // regulator_control_reg
  localparam logic [7:0] REG_IRQEN_OFS    = 8'h08; // Wake enables and global enable
  localparam logic [7:0] REG_IRQFLG_OFS   = 8'h0C; // Interrupt flags, write 1 to clear
  localparam logic [7:0] REG_PWMSUM_OFS   = 8'h10; // pwm_irq_summary, read only
  localparam logic [7:0] REG_CLKSEL_OFS   = 8'h14; // Peripheral clock selections

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STS_PD_BIT      = 3;  // power_down_flag
  localparam int STS_TO_BIT      = 4;  // timeout_flag
  localparam int STS_ASLEEP_BIT  = 8;  // Device halted in power-down, clear during stabilisation delay
  localparam int STS_STAB_BIT    = 9;  // Stabilisation delay running
  localparam int REG_LPSEL_BIT   = 1;  // regulator_sleep_power_select
  localparam int REG_RSVD_BIT    = 0;  // Reserved, reads 1
  localparam int IEN_GIE_BIT     = 31; // global_irq_enable
  localparam int PWM_SUM_LSB     = 4;  // PWM flags sit in bits 7..4
  localparam int CLK_T1_LFO_BIT  = 0;  // Timer1 clocked from low_freq_osc
  localparam int CLK_T1_EXT_BIT  = 1;  // Timer1 clocked from timer1_ext_clock_in
  localparam int CLK_ADC_OSC_BIT = 2;  // Converter on adc_dedicated_osc
  localparam int CLK_CWG_HFO_BIT = 3;  // complementary_waveform_unit on high_freq_osc

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RST_PD      = 1'b1;
  localparam logic       RST_TO      = 1'b1;
  localparam logic       RST_LPSEL   = 1'b0;
  localparam logic [3:0] RST_CLKSEL  = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int STAB_TIME_NS    = 1000; // Extra wake delay, low-power regulator
  localparam int STAB_CYCLES     = (STAB_TIME_NS * CLK_MHZ + 999) / 1000;

endpackage

/* File: rtl/smw_sleep_ctrl.sv */
// Operation
// - Power-down entered only by executing the halt instruction.
// - Entering power-down clears watchdog; it keeps counting if enabled in sleep.
// - Entering power-down clears power_down_flag and sets timeout_flag.
// - Core clock stops in power-down; low_freq_osc keeps running.
// - Timer1 runs in power-down when clocked from low_freq_osc or external input.
// - Converter keeps running in power-down when on adc_dedicated_osc.
// - Port outputs hold their pre-halt drive state during power-down.
// - Non-watchdog resets act the same asleep or awake.
// - Wake on resets, watchdog, external or sleep-capable peripheral interrupts.
// - Interrupt wakes only if individually enabled, regardless of global_irq_enable.
// - Next instruction prefetched; with global enable clear, execution resumes there.
// - With global enable set, run next instruction then branch to service routine.
// - Watchdog cleared on every wake, whatever the source.
// - Enabled flag already set before halt: halt is a no-op, nothing changes.
// - Flag set during or after halt: halt completes, wakes at once, flags updated.
// - regulator_sleep_power_select puts regulator in low-power during power-down.
// - Wake from low-power regulator adds stabilisation delay; default mode does not.
// - Regulator stays normal in power-down if an incompatible peripheral is enabled.
// - high_freq_osc may stay on in power-down for the waveform unit.
// - PWM summary bits read-only, cleared only inside each PWM module.
// - Flags set on condition regardless of enables.
// - Select bit 1 means low-power regulator, 0 normal with faster wake.
// - Watchdog time-out in power-down wakes instead of resetting, updates flags.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module smw_sleep_ctrl #(
  parameter int NUM_IRQ     = 8,                        // Wake-capable interrupt lines
  parameter int STAB_CYCLES = smw_pkg::STAB_CYCLES      // Low-power wake delay
) (
  input  wire logic               pclk,               // 200 MHz clock
  input  wire logic               presetn,            // Async reset, active low
  input  wire logic               psel,               // APB select
  input  wire logic               penable,            // APB enable
  input  wire logic               pwrite,             // APB direction
  input  wire logic [7:0]         paddr,              // APB byte address
  input  wire logic [31:0]        pwdata,             // APB write data
  output logic [31:0]             prdata,             // APB read data
  output logic                    pready,             // APB ready
  output logic                    pslverr,            // APB error
  input  wire logic               halt_exec,          // Core executes halt, one pulse
  input  wire logic [NUM_IRQ-1:0] irq_event,          // Interrupt conditions, pulses
  input  wire logic [NUM_IRQ-1:0] irq_sleep_capable,  // Source can run in power-down
  input  wire logic [3:0]         pwm_module_flags,   // Flags inside PWM modules
  input  wire logic               wdt_sleep_enabled,  // Watchdog runs in power-down
  input  wire logic               wdt_timeout,        // Watchdog time-out pulse
  input  wire logic               lp_incompat_active, // Peripheral needs normal regulator
  input  wire logic               cwg_hfo_needed,     // Waveform unit requests high_freq_osc
  input  wire logic [7:0]         port_out_in,        // Port drive values from core
  input  wire logic [7:0]         port_oe_in,         // Port enables from core
  output logic                    core_clk_en,        // Core clock gate
  output logic                    wdt_clear,          // Watchdog and prescaler clear
  output logic                    wdt_run,            // Watchdog counting allowed
  output logic                    lfo_en,             // low_freq_osc enable
  output logic                    hfo_en,             // high_freq_osc enable
  output logic                    t1_clk_en,          // Timer1 clock enable
  output logic                    adc_clk_en,         // Converter clock enable
  output logic                    reg_lowpower,       // Regulator low-power state
  output logic                    resume_pulse,       // Core resumes at prefetched PC+1
  output logic                    isr_pending,        // Branch to service after next op
  output logic                    halt_nop,           // Halt acted as no-op
  output logic [7:0]              port_out,           // Held port drive values
  output logic [7:0]              port_oe             // Held port enables
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STAB} smw_state_type;

  smw_state_type      state_ff, nxt_state;
  logic               pd_ff, to_ff, lpsel_ff, gie_ff;
  logic [NUM_IRQ-1:0] ien_ff, iflag_ff;
  logic [3:0]         clksel_ff;
  logic [31:0]        stab_ff;
  logic [31:0]        prdata_ff;
  logic [3:0]         pwm_s1_ff, pwm_s2_ff;
  logic [7:0]         pout_ff, poe_ff;
  logic               wdt_clear_ff, resume_ff, isr_ff, nop_ff;
  logic               wr_en, rd_en, addr_ok, pending, wake_ev;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign addr_ok = (paddr == smw_pkg::REG_STATUS_OFS) || (paddr == smw_pkg::REG_REGCTL_OFS) ||
                   (paddr == smw_pkg::REG_IRQEN_OFS)  || (paddr == smw_pkg::REG_IRQFLG_OFS) ||
                   (paddr == smw_pkg::REG_PWMSUM_OFS) || (paddr == smw_pkg::REG_CLKSEL_OFS);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_ff;

  // Enabled interrupt pending, global enable not considered
  assign pending = |(iflag_ff & ien_ff);
  // Wake source: pending enabled flag or watchdog time-out
  assign wake_ev = pending || (wdt_timeout && wdt_sleep_enabled);

  // PWM summary flags synchronised from module clock domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_s1_ff <= 4'h0;
      pwm_s2_ff <= 4'h0;
    end else begin
      pwm_s1_ff <= pwm_module_flags;
      pwm_s2_ff <= pwm_s1_ff;
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_ff <= 32'h0000_0000;
      unique case (paddr)
        smw_pkg::REG_STATUS_OFS: begin
          prdata_ff[smw_pkg::STS_PD_BIT]     <= pd_ff;
          prdata_ff[smw_pkg::STS_TO_BIT]     <= to_ff;
          prdata_ff[smw_pkg::STS_ASLEEP_BIT] <= (state_ff == ST_SLEEP);
          prdata_ff[smw_pkg::STS_STAB_BIT]   <= (state_ff == ST_STAB);
        end
        smw_pkg::REG_REGCTL_OFS: begin
          prdata_ff[smw_pkg::REG_LPSEL_BIT] <= lpsel_ff;
          prdata_ff[smw_pkg::REG_RSVD_BIT]  <= 1'b1;
        end
        smw_pkg::REG_IRQEN_OFS: begin
          prdata_ff[NUM_IRQ-1:0]           <= ien_ff;
          prdata_ff[smw_pkg::IEN_GIE_BIT]  <= gie_ff;
        end
        smw_pkg::REG_IRQFLG_OFS: prdata_ff[NUM_IRQ-1:0] <= iflag_ff;
        smw_pkg::REG_PWMSUM_OFS: prdata_ff[smw_pkg::PWM_SUM_LSB +: 4] <= pwm_s2_ff;
        smw_pkg::REG_CLKSEL_OFS: prdata_ff[3:0] <= clksel_ff;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpsel_ff  <= smw_pkg::RST_LPSEL;
      ien_ff    <= '0;
      gie_ff    <= 1'b0;
      clksel_ff <= smw_pkg::RST_CLKSEL;
    end else if (wr_en) begin
      if (paddr == smw_pkg::REG_REGCTL_OFS) lpsel_ff <= pwdata[smw_pkg::REG_LPSEL_BIT];
      if (paddr == smw_pkg::REG_IRQEN_OFS) begin
        ien_ff <= pwdata[NUM_IRQ-1:0];
        gie_ff <= pwdata[smw_pkg::IEN_GIE_BIT];
      end
      if (paddr == smw_pkg::REG_CLKSEL_OFS) clksel_ff <= pwdata[3:0];
    end
  end

  // Interrupt flags: set on condition regardless of enables, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iflag_ff <= '0;
    end else begin
      if (wr_en && paddr == smw_pkg::REG_IRQFLG_OFS)
        iflag_ff <= (iflag_ff & ~pwdata[NUM_IRQ-1:0]) | irq_event;
      else
        iflag_ff <= iflag_ff | irq_event;
    end
  end

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN:   if (halt_exec && !pending) nxt_state = ST_SLEEP;
      ST_SLEEP: if (wake_ev)
                  nxt_state = reg_lowpower ? ST_STAB : ST_RUN;
      ST_STAB:  if (stab_ff >= 32'(STAB_CYCLES - 1)) nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_ff <= ST_RUN;
    else          state_ff <= nxt_state;
  end

  // Stabilisation counter for low-power regulator wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)               stab_ff <= 32'h0000_0000;
    else if (state_ff == ST_STAB) stab_ff <= stab_ff + 32'h0000_0001;
    else                        stab_ff <= 32'h0000_0000;
  end

  // Status flags updated on a completed halt entry and on a watchdog time-out in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_ff <= smw_pkg::RST_PD;
      to_ff <= smw_pkg::RST_TO;
    end else if (state_ff == ST_RUN && halt_exec && !pending) begin
      pd_ff <= 1'b0;
      to_ff <= 1'b1;
    end else if (state_ff == ST_SLEEP && wdt_timeout && wdt_sleep_enabled) begin
      to_ff <= 1'b0;
    end
  end

  // Watchdog clear on entry and on every wake; no clear on no-op halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clear_ff <= 1'b0;
    end else begin
      wdt_clear_ff <= (state_ff == ST_RUN && halt_exec && !pending) ||
                      (state_ff == ST_SLEEP && wake_ev);
    end
  end

  // Resume and service indications, no-op report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_ff <= 1'b0;
      isr_ff    <= 1'b0;
      nop_ff    <= 1'b0;
    end else begin
      resume_ff <= (state_ff != ST_RUN) && (nxt_state == ST_RUN);
      nop_ff    <= (state_ff == ST_RUN) && halt_exec && pending;
      if ((state_ff != ST_RUN) && (nxt_state == ST_RUN))
        isr_ff <= gie_ff && pending;
      else if (state_ff == ST_RUN && !halt_exec)
        isr_ff <= 1'b0;
    end
  end

  // Port drive held while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pout_ff <= 8'h00;
      poe_ff  <= 8'h00;
    end else if (state_ff == ST_RUN && nxt_state == ST_RUN) begin
      pout_ff <= port_out_in;
      poe_ff  <= port_oe_in;
    end
  end

  // ----------------------------------------------------------------
  // Clock and regulator controls
  // ----------------------------------------------------------------
  assign core_clk_en  = (state_ff == ST_RUN);
  assign lfo_en       = 1'b1;
  assign t1_clk_en    = core_clk_en || clksel_ff[smw_pkg::CLK_T1_LFO_BIT] ||
                        clksel_ff[smw_pkg::CLK_T1_EXT_BIT];
  assign adc_clk_en   = core_clk_en || clksel_ff[smw_pkg::CLK_ADC_OSC_BIT];
  assign hfo_en       = core_clk_en ||
                        (clksel_ff[smw_pkg::CLK_CWG_HFO_BIT] && cwg_hfo_needed);
  assign reg_lowpower = (state_ff == ST_SLEEP) && lpsel_ff &&
                        !lp_incompat_active;
  assign wdt_clear    = wdt_clear_ff;
  assign wdt_run      = core_clk_en || wdt_sleep_enabled;
  assign resume_pulse = resume_ff;
  assign isr_pending  = isr_ff;
  assign halt_nop     = nop_ff;
  assign port_out     = pout_ff;
  assign port_oe      = poe_ff;

endmodule

`default_nettype wire

/* File: tb/smw_sleep_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Port checker
// ------------------------------------------------
module smw_sleep_ctrl_props (
  input wire logic       pclk,               // Clock
  input wire logic       presetn,            // Reset, active low
  input wire logic       halt_exec,          // Halt pulse
  input wire logic       wdt_sleep_enabled,  // Watchdog sleep mode
  input wire logic       lp_incompat_active, // Regulator veto
  input wire logic       core_clk_en,        // Core clock gate
  input wire logic       wdt_clear,          // Watchdog clear
  input wire logic       wdt_run,            // Watchdog counting
  input wire logic       lfo_en,             // Slow oscillator
  input wire logic       reg_lowpower,       // Regulator state
  input wire logic       resume_pulse,       // Resume strobe
  input wire logic       halt_nop,           // Halt refused
  input wire logic [7:0] port_out,           // Held drive
  input wire logic [7:0] port_oe             // Held enables
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sleep_cause_a: assert property ($fell(core_clk_en) |-> $past(halt_exec))
    else $error("core clock stopped without halt");
  enter_clear_a: assert property ($fell(core_clk_en) |-> wdt_clear)
    else $error("no watchdog clear on entry");
  wdt_sleep_a: assert property ($fell(core_clk_en) |-> wdt_run == wdt_sleep_enabled)
    else $error("watchdog run wrong in sleep");
  nop_quiet_a: assert property (halt_nop |-> core_clk_en && !wdt_clear ##1 core_clk_en)
    else $error("refused halt had side effects");
  halt_answer_a: assert property (halt_exec && core_clk_en |=> !core_clk_en || halt_nop)
    else $error("halt neither slept nor refused");
  port_hold_a: assert property (!core_clk_en [*2] |-> $stable(port_out) && $stable(port_oe))
    else $error("port changed while halted");
  resume_pulse_a: assert property ($rose(core_clk_en) |-> resume_pulse ##1 !resume_pulse)
    else $error("resume strobe wrong");
  reg_lp_a: assert property (reg_lowpower |-> !core_clk_en && !lp_incompat_active)
    else $error("regulator low power out of place");
  lfo_run_a: assert property (lfo_en)
    else $error("slow oscillator stopped");
endmodule
bind smw_sleep_ctrl smw_sleep_ctrl_props u_props (.*);
`default_nettype wire

/* File: tb/smw_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Core stand-in
// ------------------------------------------------
module smw_core_model (
  input  wire logic       pclk,        // Clock
  input  wire logic       presetn,     // Reset, active low
  input  wire logic       core_clk_en, // Core clock gate
  input  wire logic       halt_req,    // Bench asks for a halt
  output logic            halt_exec,   // Halt executed, one pulse
  output logic [7:0]      port_out_in, // Program drive values
  output logic [7:0]      port_oe_in   // Program enables
);
  // Halt only from a running core, one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) halt_exec <= 1'b0;
    else halt_exec <= halt_req && core_clk_en && !halt_exec;
  end
  // Ports move while running, scramble when stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out_in <= 8'h00;
      port_oe_in  <= 8'h00;
    end else begin
      port_out_in <= core_clk_en ? port_out_in + 8'h1D : ~port_out_in;
      port_oe_in  <= core_clk_en ? port_oe_in + 8'h0B : ~port_oe_in;
    end
  end
endmodule
`default_nettype wire

/* File: tb/sleep_mode_wake_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_wake_control_tb;
  localparam int STAB = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_req, halt_exec;
  logic        wdt_sleep_enabled, wdt_timeout, lp_incompat_active, cwg_hfo_needed, er;
  logic        core_clk_en, wdt_clear, resume_pulse, isr_pending, halt_nop;
  logic        wdt_run, lfo_en, hfo_en, t1_clk_en, adc_clk_en, reg_lowpower;
  logic [7:0]  paddr, port_out_in, port_oe_in, port_out, port_oe, irq_event, irq_sleep_capable;
  logic [3:0]  pwm_module_flags, csel;
  logic [31:0] pwdata, prdata, rd, seed;
  int          err_total, compares, wclr, lat, lat_n, lat_lp;

  smw_sleep_ctrl #(.NUM_IRQ(8), .STAB_CYCLES(STAB)) DUT (.*);
  smw_core_model u_core (.*);

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Watchdog clear pulses seen
  always @(posedge pclk) if (wdt_clear === 1'b1) wclr <= wclr + 1;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  function automatic logic [31:0] sts(input logic pd, input logic to, input logic sl);
    sts = 32'h0;
    sts[smw_pkg::STS_PD_BIT] = pd;
    sts[smw_pkg::STS_TO_BIT] = to;
    sts[smw_pkg::STS_ASLEEP_BIT] = sl;
  endfunction
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; report_and_stop(); end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_sig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v) begin
      @(posedge pclk); #1; n++;
      if (n > 500) begin err_total++; report_and_stop(); end
    end
  endtask
  task automatic pulse_halt();
    @(posedge pclk); halt_req <= 1'b1;
    @(posedge pclk); halt_req <= 1'b0;
  endtask
  // One sleep, a masked event, then an enabled wake
  task automatic nap(input logic lp, input logic global_irq_enable, input logic [2:0] k, output int l);
    int w0;
    w0 = wclr;
    apb(1'b1, smw_pkg::REG_REGCTL_OFS, {30'h0, lp, 1'b1});
    apb(1'b1, smw_pkg::REG_IRQEN_OFS, {global_irq_enable, 23'h0, 8'h01 << k});
    pulse_halt();
    wait_sig(core_clk_en, 1'b0, l);
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("sleep status", sts(1'b0, 1'b1, 1'b1), rd);
    chk("reg lowpower", lp & !lp_incompat_active, reg_lowpower);
    chk("t1 clock", csel[0] | csel[1], t1_clk_en);
    chk("adc clock", csel[2], adc_clk_en);
    chk("hfo clock", csel[3] & cwg_hfo_needed, hfo_en);
    @(posedge pclk); irq_event <= ~(8'h01 << k);
    @(posedge pclk); irq_event <= 8'h00;
    repeat (4) @(posedge pclk);
    chk("masked wake", 1'b0, core_clk_en);
    @(posedge pclk); irq_event <= 8'h01 << k;
    @(posedge pclk); irq_event <= 8'h00;
    wait_sig(core_clk_en, 1'b1, l);
    wait_sig(resume_pulse, 1'b1, lat);
    chk("isr pending", global_irq_enable, isr_pending);
    @(posedge pclk); #1;
    chk("wdt clears", 2, wclr - w0);
    apb(1'b1, smw_pkg::REG_IRQFLG_OFS, 32'hFF);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    halt_req = 0; irq_event = 0; wdt_sleep_enabled = 0; wdt_timeout = 0;
    lp_incompat_active = 0; cwg_hfo_needed = 0; pwm_module_flags = 0;
    irq_sleep_capable = 8'hFF; seed = 33; err_total = 0; compares = 0; csel = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("status reset", sts(1'b1, 1'b1, 1'b0), rd);
    apb(1'b0, smw_pkg::REG_REGCTL_OFS, 32'h0);
    chk("regctl reset", 32'h1, rd);
    seed = xs(seed);
    pwm_module_flags <= seed[3:0];
    apb(1'b1, smw_pkg::REG_PWMSUM_OFS, 32'hFF);
    apb(1'b0, smw_pkg::REG_PWMSUM_OFS, 32'h0);
    chk("pwm summary", {24'h0, seed[3:0], 4'h0}, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 1'b1, er);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      lp_incompat_active <= seed[5];
      cwg_hfo_needed <= seed[6];
      csel = seed[10:7];
      apb(1'b1, smw_pkg::REG_CLKSEL_OFS, {28'h0, seed[10:7]});
      nap(seed[0], seed[1], seed[4:2], lat);
    end
    lp_incompat_active <= 1'b0;
    nap(1'b0, 1'b1, 3'd3, lat_n);
    nap(1'b1, 1'b0, 3'd6, lat_lp);
    chk("lowpower delay", 1'b1, lat_lp >= lat_n + STAB);
    // Pending enabled flag turns the halt into a no-op
    @(posedge pclk); irq_event <= 8'h04;
    @(posedge pclk); irq_event <= 8'h00;
    apb(1'b1, smw_pkg::REG_STATUS_OFS, 32'hFF);
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("status ro", sts(1'b0, 1'b1, 1'b0), rd);
    apb(1'b1, smw_pkg::REG_IRQEN_OFS, 32'h04);
    pulse_halt();
    wait_sig(halt_nop, 1'b1, lat);
    chk("nop runs", 1'b1, core_clk_en);
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("nop status", sts(1'b0, 1'b1, 1'b0), rd);
    apb(1'b1, smw_pkg::REG_IRQFLG_OFS, 32'hFF);
    // Watchdog time-out in sleep wakes instead of resetting
    apb(1'b1, smw_pkg::REG_IRQEN_OFS, 32'h0);
    wdt_sleep_enabled <= 1'b1;
    pulse_halt();
    wait_sig(core_clk_en, 1'b0, lat);
    @(posedge pclk); wdt_timeout <= 1'b1;
    @(posedge pclk); wdt_timeout <= 1'b0;
    wait_sig(core_clk_en, 1'b1, lat);
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("wdt wake status", sts(1'b0, 1'b0, 1'b0), rd);
    // Reset while halted restarts; a later refused halt leaves power_down_flag set
    pulse_halt();
    wait_sig(core_clk_en, 1'b0, lat);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset wake", 1'b1, core_clk_en);
    presetn <= 1'b1;
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("reset status", sts(1'b1, 1'b1, 1'b0), rd);
    @(posedge pclk); irq_event <= 8'h01;
    @(posedge pclk); irq_event <= 8'h00;
    apb(1'b1, smw_pkg::REG_IRQEN_OFS, 32'h01);
    pulse_halt();
    wait_sig(halt_nop, 1'b1, lat);
    apb(1'b0, smw_pkg::REG_STATUS_OFS, 32'h0);
    chk("refused halt pd", sts(1'b1, 1'b1, 1'b0), rd);
    report_and_stop();
  end
endmodule
`default_nettype wire
